// File: core/flash_power_mode_reset_control.sv
/*
  Power-mode and reset sequencing of a serial NOR flash: active and standby power,
  deep power-down entry and release, power-on reset and the shared reset pin.
  Assumes write status and quad enable come from logic on ref_clk; chip select, the
  serial clock and the shared data line come from the host; all but the serial clock are synchronised here.
*/
// Summary of operation
// - Chip select low from standby means selected and in active power.
// - After deselect stay active until pending writes finish, then standby.
// - Command B9h from standby enters sleep after deselect and entry delay.
// - Sleep command accepted only while write in progress reads zero.
// - In sleep only the release command ABh is obeyed.
// - After release command, standby follows deselect plus release delay.
// - Power-on reset runs for the power-up delay from supply valid.
// - Data line three is reset input after deselect time or quad disabled.
// - Reset pin level is ignored while power-on reset runs.
// - Power-up ends in standby if data line three is high, else held in reset until it rises; the write-enable latch is cleared.
// - Reset pulse aborts work, floats outputs, blocks commands for recovery time.
module flash_power_mode_reset_control
  import flash_power_pkg::*;
#(
  parameter int POWER_UP_COUNT    = flash_power_pkg::POWER_UP_CYCLES,
  parameter int SLEEP_ENTRY_COUNT = flash_power_pkg::SLEEP_ENTRY_CYCLES,
  parameter int RELEASE_COUNT     = flash_power_pkg::RELEASE_CYCLES
)(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic serialDataIn,
  input  wire logic quadDataLineThree,
  input  wire logic writeInProgress,
  input  wire logic quadEnable,
  output logic      activePower,
  output logic      standbyPower,
  output logic      deepPowerDown,
  output logic      porBusy,
  output logic      commandsBlocked,
  output logic      outputsHighZ,
  output logic      abortOperation,
  output logic      clearWriteEnableLatch
);

  // ----------------------------------------------------------------
  // Serial-clock domain
  // ----------------------------------------------------------------
  logic [7:0] linkCmd;
  logic       linkReady;

  link_command_capture u_capture (
    .sck          (sck),
    .csN          (csN),
    .serialDataIn (serialDataIn),
    .cmdByte      (linkCmd),
    .cmdReady     (linkReady)
  );

  // ----------------------------------------------------------------
  // Crossing into ref_clk
  // ----------------------------------------------------------------
  // Bit 0 chip select, bit 1 shared data line, bit 2 command ready.
  logic [2:0] metaQ;
  logic [2:0] syncQ;
  logic       readyPrevQ;
  logic       csPrevQ;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      metaQ      <= 3'h3;
      syncQ      <= 3'h3;
      readyPrevQ <= 1'b0;
      csPrevQ    <= 1'b1;
    end else begin
      metaQ      <= {linkReady, quadDataLineThree, csN};
      syncQ      <= metaQ;
      readyPrevQ <= syncQ[2];
      csPrevQ    <= syncQ[0];
    end
  end

  logic csHigh;
  logic pinHigh;
  logic csRise;
  logic csFall;
  logic readyRise;

  assign csHigh    = syncQ[0];
  assign pinHigh   = syncQ[1];
  assign csRise    = csHigh && !csPrevQ;
  assign csFall    = !csHigh && csPrevQ;
  assign readyRise = syncQ[2] && !readyPrevQ;

  // ----------------------------------------------------------------
  // Command of the current frame
  // ----------------------------------------------------------------
  // The byte is stable while the ready flag is set, so it is taken on
  // the synchronised edge of that flag rather than synchronised itself.
  logic [7:0] frameCmdQ;
  logic [7:0] frameCmdD;
  logic       frameValidQ;
  logic       frameValidD;

  always_comb begin
    frameCmdD   = frameCmdQ;
    frameValidD = frameValidQ;
    if (csFall) begin
      frameValidD = 1'b0;
    end
    if (readyRise) begin
      frameCmdD   = linkCmd;
      frameValidD = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frameCmdQ   <= 8'h00;
      frameValidQ <= 1'b0;
    end else begin
      frameCmdQ   <= frameCmdD;
      frameValidQ <= frameValidD;
    end
  end

  logic sleepCmd;
  logic releaseCmd;

  assign sleepCmd   = frameValidQ && (frameCmdQ == CMD_ENTER_SLEEP);
  assign releaseCmd = frameValidQ && (frameCmdQ == CMD_RELEASE);

  // ----------------------------------------------------------------
  // Reset pin qualification
  // ----------------------------------------------------------------
  small_t deselCntQ;
  small_t deselCntD;
  small_t lowCntQ;
  small_t lowCntD;
  logic   pinIsReset;

  always_comb begin
    deselCntD = SMALL_ZERO;
    if (csHigh) begin
      deselCntD = (deselCntQ == small_t'(DESELECT_CYCLES)) ? deselCntQ : deselCntQ + SMALL_ONE;
    end
  end

  assign pinIsReset = !quadEnable || (deselCntQ == small_t'(DESELECT_CYCLES));

  always_comb begin
    lowCntD = SMALL_ZERO;
    if (pinIsReset && !pinHigh) begin
      lowCntD = (lowCntQ == small_t'(PULSE_CYCLES)) ? lowCntQ : lowCntQ + SMALL_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      deselCntQ <= SMALL_ZERO;
      lowCntQ   <= SMALL_ZERO;
    end else begin
      deselCntQ <= deselCntD;
      lowCntQ   <= lowCntD;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  power_state_e stateQ;
  power_state_e stateD;
  timer_t       timerQ;
  timer_t       timerD;
  logic         abortD;
  logic         clearWelD;
  logic         pulseDone;

  assign pulseDone = (lowCntQ == small_t'(PULSE_CYCLES));

  always_comb begin
    stateD    = stateQ;
    timerD    = (timerQ == TIMER_ZERO) ? TIMER_ZERO : timerQ - TIMER_ONE;
    abortD    = 1'b0;
    clearWelD = 1'b0;
    unique case (stateQ)
      PowerOn: begin
        // The pin is not looked at until the counter expires.
        if (timerQ == TIMER_ZERO) begin
          clearWelD = 1'b1;
          stateD    = pinHigh ? Standby : HwReset;
        end
      end
      Standby: begin
        if (!csHigh) begin
          stateD = Active;
        end
      end
      Active: begin
        if (csRise) begin
          if (sleepCmd && !writeInProgress) begin
            stateD = EnterSleep;
            timerD = timer_t'(SLEEP_ENTRY_COUNT);
          end else if (writeInProgress) begin
            stateD = Draining;
          end else begin
            stateD = Standby;
          end
        end
      end
      Draining: begin
        if (!csHigh) begin
          stateD = Active;
        end else if (!writeInProgress) begin
          stateD = Standby;
        end
      end
      EnterSleep: begin
        if (timerQ == TIMER_ZERO) begin
          stateD = Sleep;
        end
      end
      Sleep: begin
        // Selection with an idle clock or any other code leaves it asleep.
        if (csRise && releaseCmd) begin
          stateD = Releasing;
          timerD = timer_t'(RELEASE_COUNT);
        end
      end
      Releasing: begin
        if (timerQ == TIMER_ZERO) begin
          stateD = Standby;
        end
      end
      HwReset: begin
        // Held until recovery has run out and the pin is high again, so a
        // pin still low cannot retrigger a second reset.
        if (timerQ == TIMER_ZERO && pinHigh) begin
          stateD    = Standby;
          clearWelD = 1'b1;
        end
      end
    endcase
    if (stateQ != PowerOn && stateQ != HwReset && pulseDone) begin
      stateD = HwReset;
      timerD = timer_t'(RECOVERY_CYCLES - PULSE_CYCLES);
      abortD = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stateQ <= PowerOn;
      timerQ <= timer_t'(POWER_UP_COUNT);
    end else begin
      stateQ <= stateD;
      timerQ <= timerD;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [7:0] outQ;
  logic [7:0] outD;

  always_comb begin
    outD[0] = stateD inside {Active, Draining, EnterSleep};
    outD[1] = (stateD == Standby);
    outD[2] = (stateD == Sleep);
    outD[3] = (stateD == PowerOn);
    outD[4] = stateD inside {PowerOn, HwReset, EnterSleep, Sleep, Releasing};
    outD[5] = stateD inside {PowerOn, HwReset};
    outD[6] = abortD;
    outD[7] = clearWelD;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outQ <= 8'h38;
    end else begin
      outQ <= outD;
    end
  end

  assign activePower           = outQ[0];
  assign standbyPower          = outQ[1];
  assign deepPowerDown         = outQ[2];
  assign porBusy               = outQ[3];
  assign commandsBlocked       = outQ[4];
  assign outputsHighZ          = outQ[5];
  assign abortOperation        = outQ[6];
  assign clearWriteEnableLatch = outQ[7];

endmodule : flash_power_mode_reset_control

// File: core/flash_power_pkg.sv
/*
  Constants shared by the power-mode and reset control of the serial flash.
  Assumes a 40 MHz system clock; every cycle count is derived from it here.
*/
package flash_power_pkg;

  // ----------------------------------------------------------------
  // Clock and command codes
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam logic [7:0] CMD_ENTER_SLEEP = 8'hb9;
  localparam logic [7:0] CMD_RELEASE     = 8'hab;
  localparam int CMD_BITS = 8;

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int POWER_UP_DELAY_US         = 300;
  localparam int SLEEP_ENTRY_DELAY_NS      = 3000;
  localparam int RELEASE_DELAY_NS          = 3000;
  localparam int DESELECT_TIME_NS          = 50;
  localparam int RESTART_PULSE_WIDTH_NS    = 200;
  localparam int RESTART_RECOVERY_TIME_US  = 35;

  // ----------------------------------------------------------------
  // Cycle counts; least times round up, the power-up limit rounds down
  // ----------------------------------------------------------------
  localparam int POWER_UP_CYCLES      = POWER_UP_DELAY_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_CYCLES   = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int RELEASE_CYCLES       = (RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int DESELECT_CYCLES      = (DESELECT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYCLES         = (RESTART_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVERY_CYCLES      = RESTART_RECOVERY_TIME_US * CLK_MHZ;

  localparam int TIMER_W = 16;
  localparam int SMALL_W = 4;
  typedef logic [TIMER_W-1:0] timer_t;
  typedef logic [SMALL_W-1:0] small_t;

  localparam timer_t TIMER_ZERO = 16'h0000;
  localparam timer_t TIMER_ONE  = 16'h0001;
  localparam small_t SMALL_ZERO = 4'h0;
  localparam small_t SMALL_ONE  = 4'h1;

  typedef enum logic [2:0] {
    PowerOn,
    Standby,
    Active,
    Draining,
    EnterSleep,
    Sleep,
    Releasing,
    HwReset
  } power_state_e;

endpackage : flash_power_pkg

// File: core/link_command_capture.sv
/*
  Serial-clock side of the command path: shifts in the first command byte of a frame.
  Assumes chip select high ends the frame; it clears this logic as an asynchronous reset,
  since the serial clock stands still between frames.
*/
module link_command_capture
  import flash_power_pkg::*;
(
  input  wire logic       sck,
  input  wire logic       csN,
  input  wire logic       serialDataIn,
  output logic      [7:0] cmdByte,
  output logic            cmdReady
);

  logic [7:0] shiftQ;
  logic [7:0] shiftD;
  logic [3:0] bitCountQ;
  logic [3:0] bitCountD;
  logic       readyQ;
  logic       readyD;

  // ----------------------------------------------------------------
  // Shift the first byte, most significant bit first
  // ----------------------------------------------------------------
  always_comb begin
    shiftD    = shiftQ;
    bitCountD = bitCountQ;
    readyD    = readyQ;
    if (!readyQ) begin
      shiftD    = {shiftQ[6:0], serialDataIn};
      bitCountD = bitCountQ + 4'h1;
      if (bitCountQ == 4'(CMD_BITS - 1)) begin
        readyD = 1'b1;
      end
    end
  end

  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      shiftQ    <= 8'h00;
      bitCountQ <= 4'h0;
      readyQ    <= 1'b0;
    end else begin
      shiftQ    <= shiftD;
      bitCountQ <= bitCountD;
      readyQ    <= readyD;
    end
  end

  assign cmdByte  = shiftQ;
  assign cmdReady = readyQ;

endmodule : link_command_capture

// File: sim/flash_power_assertions.sv
/*
  Checker of the power-mode and reset control, bound to the top module's ports.
  Assumes the short counts of the bench reach it through the bind.
*/
module flash_power_assertions
  import flash_power_pkg::*;
#(
  parameter int POWER_UP_COUNT    = 20,
  parameter int SLEEP_ENTRY_COUNT = 5,
  parameter int RELEASE_COUNT     = 5
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic quadDataLineThree,
  input wire logic writeInProgress,
  input wire logic activePower,
  input wire logic standbyPower,
  input wire logic deepPowerDown,
  input wire logic porBusy,
  input wire logic commandsBlocked,
  input wire logic outputsHighZ,
  input wire logic abortOperation,
  input wire logic clearWriteEnableLatch
);
  import flash_power_pkg::*;
  int porCnt;
  int hzCnt;

  // Counts cycles since reset release, up to 1000, and since the last abort while the outputs stay high-Z.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      porCnt <= 0;
      hzCnt  <= 0;
    end else begin
      porCnt <= (porCnt < 1000) ? porCnt + 1 : porCnt;
      hzCnt  <= abortOperation ? 1 : (hzCnt != 0 && outputsHighZ) ? hzCnt + 1 : 0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_por_hold: assert property (porCnt < POWER_UP_COUNT |-> porBusy && outputsHighZ)
    else $error("power-on reset ended early");
  a_por_end: assert property (porCnt == POWER_UP_COUNT + 3 |-> !porBusy)
    else $error("power-on reset ran too long");
  a_por_standby: assert property ($fell(porBusy) && !outputsHighZ |->
    standbyPower && clearWriteEnableLatch)
    else $error("power-up did not end in standby");
  a_sel_active: assert property (standbyPower && !csN && quadDataLineThree |->
    ##[1:5] (activePower || outputsHighZ))
    else $error("selection did not give active power");
  a_drain_hold: assert property (activePower && writeInProgress && $past(writeInProgress)
    |=> !standbyPower)
    else $error("standby while a write is pending");
  a_entry_delay: assert property ($rose(deepPowerDown) |->
    $past(activePower && commandsBlocked, SLEEP_ENTRY_COUNT - 1))
    else $error("sleep entered without the entry delay");
  a_sleep_quiet: assert property (deepPowerDown |->
    commandsBlocked && !activePower && !standbyPower)
    else $error("sleep state not quiet");
  a_release_delay: assert property ($rose(standbyPower) && $past(commandsBlocked)
    && !$past(outputsHighZ) |->
    $past(commandsBlocked && !deepPowerDown && !activePower, RELEASE_COUNT - 1))
    else $error("release ended without the release delay");
  a_abort_cause: assert property (abortOperation |-> outputsHighZ
    && $past(!quadDataLineThree, 4) && $past(!quadDataLineThree, 9))
    else $error("abort without a long enough reset pulse");
  a_reset_recovery: assert property (hzCnt != 0 && hzCnt < RECOVERY_CYCLES - PULSE_CYCLES - 12
    |-> outputsHighZ && commandsBlocked && !standbyPower)
    else $error("hardware reset recovery cut short");
endmodule : flash_power_assertions

// File: sim/host_model.sv
/*
  Host model: sends one command frame for each request from the bench.
  Assumes requests arrive on ref_clk; the serial clock runs only inside frames.
*/
module host_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] cmdIn,
  input  wire logic [3:0] bitCount,
  output logic            sck,
  output logic            csN,
  output logic            serialDataIn,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck = 1'b0;
    csN = 1'b1;
    serialDataIn = 1'b0;
    busy = 1'b0;
  end

  // Chip select moves only around a frame, never while the serial clock is toggling.
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      busy = 1'b1;
      csN <= 1'b0;
      // An odd offset keeps the serial clock out of step with ref_clk.
      #17.3;
      for (int i = 0; i < bitCount; i++) begin
        serialDataIn = cmdIn[7 - i];
        #7.5 sck = 1'b1;
        #7.5 sck = 1'b0;
      end
      serialDataIn = ~serialDataIn;
      repeat (5) @(posedge ref_clk);
      csN <= 1'b1;
      repeat (6) @(posedge ref_clk);
      busy = 1'b0;
    end
  end
endmodule : host_model

// File: sim/testbench.sv
/*
  Self-checking bench of the power-mode and reset control.
  Assumes short counts through parameters; the host model makes the serial clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_power_pkg::*;
  localparam int PU = 20;
  localparam int SE = 5;
  localparam int RL = 5;
  logic       ref_clk, rst_n, sck, csN, serialDataIn, pin, write_in_progress, qe, go, busy;
  logic       activePower, standbyPower, deepPowerDown, porBusy, commandsBlocked;
  logic       outputsHighZ, abortOperation, clearWriteEnableLatch;
  logic [7:0] cmd, c;
  logic [3:0] bits;
  logic       w;
  int         mismatches, n_tests, aborts, clears, seed;

  always #12.5 ref_clk = ~ref_clk;

  flash_power_mode_reset_control #(.POWER_UP_COUNT(PU), .SLEEP_ENTRY_COUNT(SE),
    .RELEASE_COUNT(RL)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .csN(csN), .serialDataIn(serialDataIn),
    .quadDataLineThree(pin), .writeInProgress(write_in_progress), .quadEnable(qe),
    .activePower(activePower), .standbyPower(standbyPower), .deepPowerDown(deepPowerDown),
    .porBusy(porBusy), .commandsBlocked(commandsBlocked), .outputsHighZ(outputsHighZ),
    .abortOperation(abortOperation), .clearWriteEnableLatch(clearWriteEnableLatch));

  host_model host_u (.ref_clk(ref_clk), .go(go), .cmdIn(cmd), .bitCount(bits), .sck(sck),
    .csN(csN), .serialDataIn(serialDataIn), .busy(busy));

  // Pulses are counted at the falling edge, where the registered outputs have settled.
  always @(negedge ref_clk) begin
    if (abortOperation === 1'b1) aborts++;
    if (clearWriteEnableLatch === 1'b1) clears++;
  end

  task check(input string name, input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  task finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = deepPowerDown;
      1: pick = standbyPower;
      2: pick = !porBusy;
      3: pick = !busy;
      default: pick = outputsHighZ;
    endcase
  endfunction : pick

  function automatic logic expectSleep(input logic [7:0] code, input logic pending);
    return code == CMD_ENTER_SLEEP && !pending;
  endfunction : expectSleep

  // Checks at falling edges so that the rising edge's updates have landed.
  task automatic waitFor(input int sel, input int lim);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (pick(sel) !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        mismatches++;
        finish_test();
      end
    end
    @(posedge ref_clk);
  endtask : waitFor

  task automatic frame(input logic [7:0] code, input logic [3:0] n);
    logic s;
    s = deepPowerDown;
    go <= 1'b1;
    cmd <= code;
    bits <= n;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    check("activePower", activePower, !s);
    waitFor(3, 40);
  endtask : frame

  initial begin
    ref_clk = 0; rst_n = 0; go = 0; cmd = 0; bits = 0; pin = 1; write_in_progress = 0; qe = 1;
    seed = 6; mismatches = 0; n_tests = 0; aborts = 0; clears = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    pin <= 1'b1;
    waitFor(2, PU + 10);
    @(negedge ref_clk);
    check("standbyPower", standbyPower, 1'b1);
    check("no abort", aborts == 0, 1'b1);
    $display("Test power-up done");
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? CMD_ENTER_SLEEP : 8'($random(seed));
      w = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
      write_in_progress <= w;
      frame(c, 4'h8);
      repeat (SE + 8) @(posedge ref_clk);
      @(negedge ref_clk);
      check("deepPowerDown", deepPowerDown, expectSleep(c, w));
      check("activePower", activePower, w);
      @(posedge ref_clk);
      write_in_progress <= 1'b0;
      if (expectSleep(c, w)) begin
        frame(8'h00, 4'h0);
        c = 8'($random(seed));
        frame((c == CMD_RELEASE) ? 8'h00 : c, 4'h8);
        @(negedge ref_clk);
        check("deepPowerDown", deepPowerDown, 1'b1);
        @(posedge ref_clk);
        frame(CMD_RELEASE, 4'h8);
      end
      waitFor(1, RL + 20);
      $display("Test frame %0d done", i);
    end
    // A short pulse must not reset; the long one resets with either qualifier.
    for (int q = 1; q >= 0; q--) begin
      qe <= q[0];
      pin <= 1'b0;
      repeat (5) @(posedge ref_clk);
      pin <= 1'b1;
      repeat (12) @(posedge ref_clk);
      pin <= 1'b0;
      waitFor(4, 14);
      repeat (1000) @(posedge ref_clk);
      @(negedge ref_clk);
      check("commandsBlocked", commandsBlocked, 1'b1);
      @(posedge ref_clk);
      pin <= 1'b1;
      waitFor(1, 500);
      check("abort count", aborts == 2 - q, 1'b1);
      repeat (4) @(posedge ref_clk);
      $display("Test reset pin %0d done", q);
    end
    check("latch clears", clears == 3, 1'b1);
    // Reset again with the pin held low past power-up: no abort, held until the pin rises.
    rst_n <= 1'b0;
    pin   <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    waitFor(2, PU + 10);
    @(negedge ref_clk);
    check("outputsHighZ", outputsHighZ, 1'b1);
    check("standbyPower", standbyPower, 1'b0);
    @(posedge ref_clk);
    pin <= 1'b1;
    waitFor(1, 10);
    check("abort count", aborts == 2, 1'b1);
    // The host waits out the hold time after the pin rises before selecting.
    repeat (4) @(posedge ref_clk);
    frame(8'h00, 4'h8);
    $display("Test held reset done");
    finish_test();
  end
endmodule : testbench

bind flash_power_mode_reset_control flash_power_assertions #(
  .POWER_UP_COUNT(POWER_UP_COUNT), .SLEEP_ENTRY_COUNT(SLEEP_ENTRY_COUNT),
  .RELEASE_COUNT(RELEASE_COUNT)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .csN(csN), .quadDataLineThree(quadDataLineThree),
  .writeInProgress(writeInProgress), .activePower(activePower), .standbyPower(standbyPower),
  .deepPowerDown(deepPowerDown), .porBusy(porBusy), .commandsBlocked(commandsBlocked),
  .outputsHighZ(outputsHighZ), .abortOperation(abortOperation),
  .clearWriteEnableLatch(clearWriteEnableLatch));
